// ---- logic/pup_port_slice.sv ----
// pull-up select registers and output latches of the two-pin and eight-pin ports
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pup_defs.svh"
module pup_port_slice #(
	parameter int ADDR_W = 18
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// direction from the mode register, 1 = input mode
	input wire logic [1:0] port8Dir,
	input wire logic [7:0] port9Dir,
	// pin levels
	input wire logic [1:0] port8PinIn,
	input wire logic [7:0] port9PinIn,
	// pin drive and pull-up enables
	output pup_pkg::pup_pins2_t port8Pins,
	output pup_pkg::pup_pins8_t port9Pins
);
	import pup_pkg::*;

	// ********************
	// decoding helpers
	// ********************

	// the two low address bits are ignored, so unaligned accesses hit the word
	function automatic pup_sel_t decodeSel(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] idx;
		idx = a[ADDR_W-1:2];
		case (idx)
			(ADDR_W-2)'(`PUP_IDX_PU8): begin
				decodeSel = SEL_PU8;
			end
			(ADDR_W-2)'(`PUP_IDX_PU9): begin
				decodeSel = SEL_PU9;
			end
			(ADDR_W-2)'(`PUP_IDX_P8): begin
				decodeSel = SEL_P8;
			end
			(ADDR_W-2)'(`PUP_IDX_P9): begin
				decodeSel = SEL_P9;
			end
			(ADDR_W-2)'(`PUP_IDX_BITOP): begin
				decodeSel = SEL_BIT;
			end
			default: begin
				decodeSel = SEL_NONE;
			end
		endcase
	endfunction

	// output pins show the latch, input pins the pin level
	function automatic logic [7:0] portView(input logic [7:0] latch, input logic [7:0] pin,
		input logic [7:0] dir);
		portView = (latch & ~dir) | (pin & dir);
	endfunction

	// ********************
	// state
	// ********************

	logic awHeld;
	logic wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic wLane0;
	logic [1:0] pu8;
	logic [7:0] pu9;
	logic [1:0] latch8;
	logic [7:0] latch9;

	// ********************
	// write channel handshake
	// ********************

	wire awTake = awvalid & awready;
	wire wTake = wvalid & wready;
	wire doWrite = awHeld & wHeld & ~bvalid;
	wire next_awHeld = (awHeld | awTake) & ~doWrite;
	wire next_wHeld = (wHeld | wTake) & ~doWrite;
	wire next_bvalid = doWrite | (bvalid & ~bready);
	wire pup_sel_t wSel = decodeSel(awAddr);
	// only lane 0 carries data; a write without it changes nothing
	wire wEn = doWrite & wLane0;

	// ********************
	// views seen by reads and bit operations
	// ********************

	wire [7:0] view8 = portView({6'h00, latch8}, {6'h00, port8PinIn}, {6'h00, port8Dir});
	wire [7:0] view9 = portView(latch9, port9PinIn, port9Dir);

	// ********************
	// bit operation, done as a byte read-modify-write
	// ********************

	wire [2:0] bitIdx = wData[`PUP_BIT_IDX +: 3];
	wire [1:0] bitTgt = wData[`PUP_BIT_TGT +: 2];
	wire [1:0] bitOp = wData[`PUP_BIT_OP +: 2];
	wire [7:0] bitMask = 8'h01 << bitIdx;
	// input bits read back as pin levels, so their latch bits lose the old value
	wire [7:0] bitSrc = (bitTgt == `PUP_TGT_P8) ? view8 :
		(bitTgt == `PUP_TGT_P9) ? view9 :
		(bitTgt == `PUP_TGT_PU8) ? {6'h00, pu8} : pu9;
	wire [7:0] bitRes = (bitOp == `PUP_OP_CLR) ? (bitSrc & ~bitMask) :
		(bitOp == `PUP_OP_SET) ? (bitSrc | bitMask) :
		(bitOp == `PUP_OP_INV) ? (bitSrc ^ bitMask) : bitSrc;
	wire bitEn = wEn & (wSel == SEL_BIT);

	// ********************
	// next register values
	// ********************

	// byte writes or bit operations both land here
	wire [7:0] next_pu8Full = (wEn & (wSel == SEL_PU8)) ? wData[7:0] :
		(bitEn & (bitTgt == `PUP_TGT_PU8)) ? bitRes : {6'h00, pu8};
	// upper bits of port 8 select are not stored
	wire [1:0] next_pu8 = next_pu8Full[1:0];
	wire [7:0] next_pu9 = (wEn & (wSel == SEL_PU9)) ? wData[7:0] :
		(bitEn & (bitTgt == `PUP_TGT_PU9)) ? bitRes : pu9;
	// latch written whatever the direction; holds otherwise
	wire [7:0] next_latch8Full = (wEn & (wSel == SEL_P8)) ? wData[7:0] :
		(bitEn & (bitTgt == `PUP_TGT_P8)) ? bitRes : {6'h00, latch8};
	wire [1:0] next_latch8 = next_latch8Full[1:0];
	wire [7:0] next_latch9 = (wEn & (wSel == SEL_P9)) ? wData[7:0] :
		(bitEn & (bitTgt == `PUP_TGT_P9)) ? bitRes : latch9;
	wire [1:0] next_bresp = (wSel == SEL_NONE) ? `PUP_RESP_SLVERR : `PUP_RESP_OKAY;

	// ********************
	// read channel
	// ********************

	wire arTake = arvalid & arready;
	wire next_rvalid = arTake | (rvalid & ~rready);
	wire pup_sel_t rSel = decodeSel(araddr);
	wire [7:0] rByte = (rSel == SEL_PU8) ? {6'h00, pu8} :
		(rSel == SEL_PU9) ? pu9 :
		(rSel == SEL_P8) ? view8 :
		(rSel == SEL_P9) ? view9 : 8'h00;
	wire [1:0] rRespSel = (rSel == SEL_NONE) ? `PUP_RESP_SLVERR : `PUP_RESP_OKAY;

	// ********************
	// pin side
	// ********************

	// pin counts of the two ports
	localparam int P8_PINS = 2;
	localparam int P9_PINS = 8;

	// driver on only for output pins; pull-up only for input pins, alternate use included
	logic [1:0] next_oe8;
	logic [7:0] next_oe9;
	logic [1:0] next_pull8;
	logic [7:0] next_pull9;

	// a select bit alone never reaches a pin; an output must not fight its own pull-up
	generate
		for (genvar i = 0; i < P8_PINS; i++) begin : g_pin8
			assign next_oe8[i] = ~port8Dir[i];
			assign next_pull8[i] = next_pu8[i] & port8Dir[i];
		end
	endgenerate

	generate
		for (genvar i = 0; i < P9_PINS; i++) begin : g_pin9
			assign next_oe9[i] = ~port9Dir[i];
			assign next_pull9[i] = next_pu9[i] & port9Dir[i];
		end
	endgenerate

	// ********************
	// write path flops
	// ********************

	// address and data may come in either order; each waits here for the other
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
		end
	end

	// decode runs from the held address, so the master may drop the bus early
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awAddr <= '0;
		end else if (awTake) begin
			awAddr <= awaddr;
		end
	end

	// only the lane 0 strobe is kept; the other lanes carry nothing
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wData <= 32'h0000_0000;
			wLane0 <= 1'b0;
		end else if (wTake) begin
			wData <= wdata;
			wLane0 <= wstrb[0];
		end
	end

	// readies stay low while a response waits, so a second write cannot overtake it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awready <= 1'b0;
			wready <= 1'b0;
		end else begin
			awready <= ~next_awHeld & ~next_bvalid;
			wready <= ~next_wHeld & ~next_bvalid;
		end
	end

	// the code is caught with the write, so it stands as long as bvalid does
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp <= `PUP_RESP_OKAY;
		end else begin
			bvalid <= next_bvalid;
			if (doWrite) begin
				bresp <= next_bresp;
			end
		end
	end

	// ********************
	// read path flops
	// ********************

	// one read at a time: the address is refused while an answer waits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
		end else begin
			arready <= ~next_rvalid;
			rvalid <= next_rvalid;
		end
	end

	// data caught at the address edge stands until the master takes it
	// unmapped reads answer zero together with the error code
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 32'h0000_0000;
			rresp <= `PUP_RESP_OKAY;
		end else if (arTake) begin
			rdata <= {24'h000000, rByte};
			rresp <= rRespSel;
		end
	end

	// ********************
	// option registers and latches
	// ********************

	// only the two implemented select bits are stored; the rest read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pu8 <= 2'h0;
		end else begin
			pu8 <= next_pu8;
		end
	end

	// cleared by reset so that no pin starts pulled up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pu9 <= `PUP_PU_RST;
		end else begin
			pu9 <= next_pu9;
		end
	end

	// a latch is written whatever the direction; an input pin just does not show it
	// port 8 keeps only its two latch bits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			latch8 <= 2'h0;
		end else begin
			latch8 <= next_latch8;
		end
	end

	// a bit operation on port 9 rebuilds every input bit from the pin level read back
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			latch9 <= `PUP_LATCH_RST;
		end else begin
			latch9 <= next_latch9;
		end
	end

	// ********************
	// pin flops
	// ********************

	// pins start undriven and without pull-up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port8Pins <= '0;
		end else begin
			port8Pins <= '{out: next_latch8, oe: next_oe8, pull: next_pull8};
		end
	end

	// pins follow the register at the very edge that writes it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			port9Pins <= '0;
		end else begin
			port9Pins <= '{out: next_latch9, oe: next_oe9, pull: next_pull9};
		end
	end

endmodule

// ---- pkg/pup_defs.svh ----
// register indices, field positions, reset values and codes of the port slice
// Function
// - port 8 pull-up select, bit per pin
// - port 9 eight-bit pull-up select register
// - pull-up connects only on input pins
// - output pins never get the pull-up
// - same gating for alternate-function pins
// - reset clears both pull-up selects
// - output pin drives written latch value
// - latch holds until next write
// - input pin write updates latch only
// - output pin read returns latch
// - input pin read returns pin level
// - output pin RMW works on latch
// - input pin RMW leaves latch undefined
// - bit operation acts on whole byte
`ifndef PUP_DEFS_SVH
`define PUP_DEFS_SVH

// ********************
// register indices (byte address is four times the index)
// ********************
`define PUP_IDX_PU8 16'hff38
`define PUP_IDX_PU9 16'hff39
`define PUP_IDX_P8 16'hff18
`define PUP_IDX_P9 16'hff19
`define PUP_IDX_BITOP 16'hff1f

// ********************
// reset values
// ********************
`define PUP_PU_RST 8'h00
`define PUP_LATCH_RST 8'h00

// ********************
// bit operation register fields
// ********************
`define PUP_BIT_IDX 0
`define PUP_BIT_TGT 3
`define PUP_BIT_OP 5
`define PUP_TGT_P8 2'h0
`define PUP_TGT_P9 2'h1
`define PUP_TGT_PU8 2'h2
`define PUP_TGT_PU9 2'h3
`define PUP_OP_CLR 2'h0
`define PUP_OP_SET 2'h1
`define PUP_OP_INV 2'h2

// ********************
// bus answers
// ********************
`define PUP_RESP_OKAY 2'h0
`define PUP_RESP_SLVERR 2'h2

`endif

// ---- pkg/pup_pkg.sv ----
// types shared by the port slice
package pup_pkg;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_PU8,
		SEL_PU9,
		SEL_P8,
		SEL_P9,
		SEL_BIT
	} pup_sel_t;

	typedef struct packed {
		logic [1:0] out;
		logic [1:0] oe;
		logic [1:0] pull;
	} pup_pins2_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pull;
	} pup_pins8_t;

endpackage

// ---- sim/pup_pin_board.sv ----
// board model: pin levels from slice drive, pull-ups and outside sources
`timescale 1ns/1ps
module pup_pin_board (
	input wire logic clk,
	input wire pup_pkg::pup_pins2_t port8Pins,
	input wire pup_pkg::pup_pins8_t port9Pins,
	input wire logic [9:0] extDrv,
	input wire logic [9:0] extLvl,
	output logic [1:0] port8PinIn,
	output logic [7:0] port9PinIn
);
	import pup_pkg::*;
	logic flip = 1'b0;
	wire [9:0] oe = {port9Pins.oe, port8Pins.oe};
	wire [9:0] drv = {port9Pins.out, port8Pins.out};
	wire [9:0] pul = {port9Pins.pull, port8Pins.pull};
	// a floating line toggles so it never passes for a steady level
	always @(posedge clk) flip <= ~flip;
	assign {port9PinIn, port8PinIn} = (oe & drv) | (~oe & extDrv & extLvl)
		| (~oe & ~extDrv & (pul | {10{flip}}));
endmodule

// ---- sim/pup_port_slice_chk.sv ----
// assertions on the port slice pins and bus answers
`timescale 1ns/1ps
module pup_port_slice_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic [1:0] port8Dir,
	input wire logic [7:0] port9Dir,
	input wire pup_pkg::pup_pins2_t port8Pins,
	input wire pup_pkg::pup_pins8_t port9Pins
);
	import pup_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence arTaken; arvalid && arready; endsequence
	sequence rWait; rvalid && !rready; endsequence
	sequence bWait; bvalid && !bready; endsequence
	a_pull8_gate: assert property ((port8Pins.pull & ~$past(port8Dir)) == 2'h0)
		else $error("pull-up on p8 output");
	a_pull9_gate: assert property ((port9Pins.pull & ~$past(port9Dir)) == 8'h0)
		else $error("pull-up on p9 output");
	a_oe8_dir: assert property ($past(nrst) |-> port8Pins.oe == ~$past(port8Dir))
		else $error("p8 drive not from dir");
	a_oe9_dir: assert property ($past(nrst) |-> port9Pins.oe == ~$past(port9Dir))
		else $error("p9 drive not from dir");
	a_ar_answer: assert property (arTaken |=> rvalid)
		else $error("no read answer");
	a_rd_hold: assert property (rWait |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_b_hold: assert property (bWait |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_latch_hold: assert property (!$rose(bvalid) |-> $stable({port8Pins.out, port9Pins.out}))
		else $error("latch changed without write");
endmodule
bind pup_port_slice pup_port_slice_chk chk (.clk, .nrst, .arvalid, .arready, .rvalid, .rready,
	.rdata, .bvalid, .bready, .bresp, .port8Dir, .port9Dir, .port8Pins, .port9Pins);

// ---- sim/pup_port_slice_tb_top.sv ----
// self-checking bench for the port slice
`timescale 1ns/1ps
`include "pup_defs.svh"
module pup_port_slice_tb_top;
	import pup_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [17:0] awaddr = 18'h0, araddr = 18'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [1:0] port8Dir = 2'h3;
	logic [7:0] port9Dir = 8'hff;
	logic [9:0] extDrv = 10'h0, extLvl = 10'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, port8PinIn;
	logic [7:0] port9PinIn;
	logic [31:0] rdata;
	pup_pins2_t port8Pins;
	pup_pins8_t port9Pins;
	int badCount = 0, comparisons = 0;
	initial forever #12.5 clk = ~clk;
	pup_port_slice dut (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .port8Dir, .port9Dir, .port8PinIn, .port9PinIn, .port8Pins, .port9Pins);
	pup_pin_board brd (.clk, .port8Pins, .port9Pins, .extDrv, .extLvl, .port8PinIn, .port9PinIn);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			badCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a;
		logic w;
		a = 1'b1;
		w = 1'b1;
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (a || w) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			a = a && !awready;
			w = w && !wready;
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		chk(rdata, {24'h0, e});
		chk(32'(rresp), 32'(er));
	endtask
	task automatic tPull;
		rd(`PUP_IDX_PU9, 8'h00, `PUP_RESP_OKAY);
		chk(32'(port9Pins), 32'h0);
		port9Dir <= 8'hf0;
		wr(`PUP_IDX_PU9, 8'hff, `PUP_RESP_OKAY);
		chk(32'(port9Pins.pull), 32'hf0);
		wr(`PUP_IDX_PU8, 8'hff, `PUP_RESP_OKAY);
		rd(`PUP_IDX_PU8, 8'h03, `PUP_RESP_OKAY);
		chk(32'(port8Pins.pull), 32'h3);
		rd(`PUP_IDX_P9, 8'hf0, `PUP_RESP_OKAY);
		$display("pull-up test done");
	endtask
	task automatic tLatch;
		wr(`PUP_IDX_P9, 8'ha5, `PUP_RESP_OKAY);
		chk(32'({port9Pins.out, port9Pins.oe}), 32'ha50f);
		rd(`PUP_IDX_P9, 8'hf5, `PUP_RESP_OKAY);
		port9Dir <= 8'h00;
		repeat (2) @(posedge clk);
		chk(32'(port9Pins), 32'ha5ff00);
		rd(`PUP_IDX_P9, 8'ha5, `PUP_RESP_OKAY);
		$display("latch test done");
	endtask
	task automatic tBitOp;
		port9Dir <= 8'hf0;
		extDrv <= 10'h3c0;
		extLvl <= 10'h280;
		wr(`PUP_IDX_P9, 8'h00, `PUP_RESP_OKAY);
		wr(`PUP_IDX_BITOP, {1'b0, `PUP_OP_SET, `PUP_TGT_P9, 3'h1}, `PUP_RESP_OKAY);
		rd(`PUP_IDX_P9, 8'ha2, `PUP_RESP_OKAY);
		extDrv <= 10'h0;
		port9Dir <= 8'h00;
		repeat (2) @(posedge clk);
		chk(32'(port9Pins.out), 32'ha2);
		wr(`PUP_IDX_BITOP, {1'b0, `PUP_OP_CLR, `PUP_TGT_PU8, 3'h0}, `PUP_RESP_OKAY);
		rd(`PUP_IDX_PU8, 8'h02, `PUP_RESP_OKAY);
		wr(`PUP_IDX_BITOP, {1'b0, `PUP_OP_INV, `PUP_TGT_PU9, 3'h7}, `PUP_RESP_OKAY);
		rd(`PUP_IDX_PU9, 8'h7f, `PUP_RESP_OKAY);
		wr(16'h0100, 8'h55, `PUP_RESP_SLVERR);
		rd(16'h0100, 8'h00, `PUP_RESP_SLVERR);
		$display("bit operation test done");
	endtask
	task automatic stopTest;
		$display("comparisons=%0d mismatches=%0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		tPull;
		tLatch;
		tBitOp;
		stopTest;
	end
	initial begin
		repeat (3000) @(posedge clk);
		badCount++;
		stopTest;
	end
endmodule
